// >>> rtl/vipu_consts.svh
// Functional notes
// - Watchdog non-maskable request is taken unconditionally and beats every other request.
// - Any non-maskable or unmasked maskable request raises the standby release output.
// - Watchdog in watchdog mode 1 goes to the non-maskable source, vector 0004H.
// - Watchdog in interval mode goes to maskable slot 0, the highest priority.
// - Watchdog overflow reaches exactly one path, never both.
// - Each maskable request is gated by its own mask; ties follow fixed order.
// - Simultaneous maskable requests: lowest number wins, 0 highest, 21 lowest.
// - Pin edge requests 0 to 3 use slots 1 to 4, vectors 0006H to 000CH.
// - Remote edge request uses slot 5, vector 000EH.
// - Serial receive done and first sio done share slot 6, vector 0010H.
// - Slots 7 to 15 map to vectors 0012H to 0022H in table order.
// - Slot 12 fires on third timer match, or cascaded compare match in 16-bit mode.
// - First key return request uses slot 16, vector 0024H.
// - Remote error, guide pulse, receive done, shift full use slots 17 to 20.
// - Sixteen internal and five external sources; large variant adds slot 21, 002EH.
// - A request flag sets on its event and clears on acknowledge or reset.
// - Reset loads every mask register with all ones.
`ifndef VIPU_CONSTS_SVH
`define VIPU_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define VIPU_OFF_IF0 32'h0000_0000
`define VIPU_OFF_IF1 32'h0000_0004
`define VIPU_OFF_IF2 32'h0000_0008
`define VIPU_OFF_MK0 32'h0000_000C
`define VIPU_OFF_MK1 32'h0000_0010
`define VIPU_OFF_MK2 32'h0000_0014
`define VIPU_OFF_CTRL 32'h0000_0018
`define VIPU_OFF_STAT 32'h0000_001C

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define VIPU_RST_IF 24'h00_0000
`define VIPU_RST_MK 24'hFF_FFFF
`define VIPU_RST_CTRL 2'h0
`define VIPU_SRC_ALL 24'h3F_FFFF
`define VIPU_SRC_SMALL 24'h1F_FFFF
`define VIPU_CTRL_WDT_NMI 0
`define VIPU_CTRL_CASCADE 1
`define VIPU_STAT_NMI 0
`define VIPU_STAT_VALID 1
`define VIPU_STAT_IDX 8
`define VIPU_STAT_VEC 16

// ----------------------------------------
// Vectors and slots
// ----------------------------------------
`define VIPU_VEC_BASE 16'h0004
`define VIPU_VEC_NMI 16'h0004
`define VIPU_NUM_SRC 22
`define VIPU_SLOT_WDT 0
`define VIPU_SLOT_SHARED 6
`define VIPU_SLOT_TIMER_C 12

`endif

// >>> rtl/vipu_pkg.sv
package vipu_pkg;
  // Flag vector, one bit per maskable slot
  typedef logic [21:0] vipu_flags_t;
  // Slot number, 0 highest
  typedef logic [4:0] vipu_idx_t;
  // Vector table address
  typedef logic [15:0] vipu_vec_t;

  // Vector address of a maskable slot
  function automatic vipu_vec_t vipu_vector(input vipu_idx_t idx);
    vipu_vector = 16'h0004 + {10'h000, idx, 1'b0};
  endfunction
endpackage

// >>> rtl/vipu_arb_if.sv
`timescale 1ns/10ps
interface vipu_arb_if;
  import vipu_pkg::*;
  vipu_flags_t req_flags;
  vipu_flags_t masks;
  logic nmi_pend;
  logic global_en;
  logic win_valid;
  logic win_nmi;
  vipu_idx_t win_idx;
  vipu_vec_t win_vec;

  // Flag holder side
  modport ctrl (output req_flags, masks, nmi_pend, global_en,
                input win_valid, win_nmi, win_idx, win_vec);
  // Arbiter side
  modport arb (input req_flags, masks, nmi_pend, global_en,
               output win_valid, win_nmi, win_idx, win_vec);
endinterface

// >>> rtl/vipu_arbiter.sv
`timescale 1ns/10ps
`include "vipu_consts.svh"
module vipu_arbiter import vipu_pkg::*; (
  // Clock and reset, used by checks only
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Flags in, winner out
  vipu_arb_if.arb bus
);
  vipu_flags_t pend;
  vipu_idx_t low_idx;
  logic any_pend;

  // Unmasked pending requests
  assign pend = bus.req_flags & ~bus.masks;
  assign any_pend = |pend;

  // Lowest slot number wins among simultaneous requests
  always_comb begin
    low_idx = 5'h00;
    for (int i = `VIPU_NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        low_idx = 5'(i);
      end
    end
  end

  // NMI bypasses ordering and the global enable
  assign bus.win_nmi = bus.nmi_pend;
  assign bus.win_valid = bus.nmi_pend | (any_pend & bus.global_en);
  assign bus.win_idx = low_idx;
  assign bus.win_vec = bus.nmi_pend ? `VIPU_VEC_NMI : vipu_vector(low_idx);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_nmi_top_wins: assert property (bus.nmi_pend |-> bus.win_valid && bus.win_nmi && bus.win_vec == 16'h0004)
    else $error("pending nmi not selected");
  a_mask_gates_win: assert property (bus.win_valid && !bus.win_nmi |-> bus.req_flags[bus.win_idx] && !bus.masks[bus.win_idx])
    else $error("masked or idle slot selected");
  a_lowest_num_wins: assert property (bus.win_valid && !bus.win_nmi |-> (pend & ((22'h1 << bus.win_idx) - 22'h1)) == 22'h0)
    else $error("higher priority slot skipped");
  a_vector_slot_map: assert property (bus.win_valid && !bus.win_nmi |-> bus.win_vec[0] == 1'b0 && ((bus.win_vec - 16'h0004) >> 1) == {11'h000, bus.win_idx})
    else $error("vector does not match slot");
  a_global_gate: assert property (bus.win_valid |-> bus.win_nmi || bus.global_en)
    else $error("maskable vector without global enable");
endmodule

// >>> rtl/vipu_top.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "vipu_consts.svh"
module vipu_top import vipu_pkg::*; #(
  parameter bit HAS_KEY_RETURN_B = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Interrupt sources, one-cycle pulses
  input wire logic watchdog_irq_in,
  input wire logic [3:0] pin_edge_irq_in,
  input wire logic remote_edge_irq_in,
  input wire logic serial_rx_done_irq_in,
  input wire logic sio_a_done_irq_in,
  input wire logic sio_b_done_irq_in,
  input wire logic serial_tx_done_irq_in,
  input wire logic watch_interval_irq_in,
  input wire logic timer_a_match_irq_in,
  input wire logic timer_b_match_irq_in,
  input wire logic timer_c_match_irq_in,
  input wire logic timer_cascade_match_irq_in,
  input wire logic timer_d_match_irq_in,
  input wire logic adc_done_irq_in,
  input wire logic watch_overflow_irq_in,
  input wire logic key_return_a_irq_in,
  input wire logic remote_error_irq_in,
  input wire logic guide_pulse_irq_in,
  input wire logic remote_rx_done_irq_in,
  input wire logic shift_data_full_irq_in,
  input wire logic key_return_b_irq_in,
  // Processor side
  input wire logic global_enable_flag_in,
  input wire logic cpu_ack_in,
  output logic irq_valid_out,
  output logic irq_nmi_out,
  output logic [15:0] irq_vector_out,
  output logic [4:0] irq_slot_out,
  output logic standby_release_out
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  vipu_arb_if arb_bus ();
  logic [23:0] req_ff;
  logic [23:0] mask_flag_ff;
  logic [1:0] ctrl_ff;
  logic nmi_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_valid_ff;
  logic irq_nmi_ff;
  logic [15:0] irq_vector_ff;
  logic [4:0] irq_slot_ff;
  logic standby_ff;
  logic [23:0] nxt_req;
  logic [23:0] nxt_mask_flag;
  logic [1:0] nxt_ctrl;
  logic nxt_nmi;
  logic [31:0] nxt_prdata;
  logic nxt_pready;
  logic nxt_pslverr;
  logic nxt_irq_valid;
  logic nxt_standby;
  wire [23:0] src_valid;
  wire wdt_nmi_mode;
  wire cascade_mode;
  wire nmi_event;
  wire [23:0] event_vec;
  wire apb_setup;
  wire apb_wr;
  wire hit_if0;
  wire hit_if1;
  wire hit_if2;
  wire hit_mk0;
  wire hit_mk1;
  wire hit_mk2;
  wire hit_ctrl;
  wire hit_stat;
  wire mapped;
  wire [23:0] if_wmask;
  wire [23:0] mk_wmask;
  wire [23:0] wdata_rep;
  wire ack_take;
  wire ack_nmi;
  wire [23:0] ack_vec;
  wire [31:0] status_word;
  wire [31:0] rdata;

  // ----------------------------------------
  // Source collection
  // ----------------------------------------
  // Slots that exist on this variant
  assign src_valid = HAS_KEY_RETURN_B ? `VIPU_SRC_ALL : `VIPU_SRC_SMALL;
  assign wdt_nmi_mode = ctrl_ff[`VIPU_CTRL_WDT_NMI];
  assign cascade_mode = ctrl_ff[`VIPU_CTRL_CASCADE];

  // Watchdog goes to one path only, chosen by mode
  assign nmi_event = watchdog_irq_in & wdt_nmi_mode;

  // Event pulses laid out in slot order
  assign event_vec = src_valid & {
    2'b00,
    key_return_b_irq_in,
    shift_data_full_irq_in,
    remote_rx_done_irq_in,
    guide_pulse_irq_in,
    remote_error_irq_in,
    key_return_a_irq_in,
    watch_overflow_irq_in,
    adc_done_irq_in,
    timer_d_match_irq_in,
    cascade_mode ? timer_cascade_match_irq_in : timer_c_match_irq_in,
    timer_b_match_irq_in,
    timer_a_match_irq_in,
    watch_interval_irq_in,
    serial_tx_done_irq_in,
    sio_b_done_irq_in,
    serial_rx_done_irq_in | sio_a_done_irq_in,
    remote_edge_irq_in,
    pin_edge_irq_in,
    watchdog_irq_in & ~wdt_nmi_mode
  };

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign apb_setup = psel_in & ~penable_in;
  assign apb_wr = psel_in & penable_in & pwrite_in & pready_ff;
  assign hit_if0 = (paddr_in == `VIPU_OFF_IF0);
  assign hit_if1 = (paddr_in == `VIPU_OFF_IF1);
  assign hit_if2 = (paddr_in == `VIPU_OFF_IF2);
  assign hit_mk0 = (paddr_in == `VIPU_OFF_MK0);
  assign hit_mk1 = (paddr_in == `VIPU_OFF_MK1);
  assign hit_mk2 = (paddr_in == `VIPU_OFF_MK2);
  assign hit_ctrl = (paddr_in == `VIPU_OFF_CTRL);
  assign hit_stat = (paddr_in == `VIPU_OFF_STAT);
  assign mapped = hit_if0 | hit_if1 | hit_if2 | hit_mk0 | hit_mk1 | hit_mk2 |
                  hit_ctrl | hit_stat;

  // Byte lane write masks over the flattened flag vectors
  assign if_wmask = {{8{apb_wr & hit_if2}}, {8{apb_wr & hit_if1}}, {8{apb_wr & hit_if0}}};
  assign mk_wmask = {{8{apb_wr & hit_mk2}}, {8{apb_wr & hit_mk1}}, {8{apb_wr & hit_mk0}}};
  assign wdata_rep = {3{pwdata_in[7:0]}};

  // Status view of the current offer
  assign status_word = {irq_vector_ff, 3'h0, irq_slot_ff, 6'h00, irq_valid_ff, irq_nmi_ff};

  // Read data selection
  assign rdata = hit_if0 ? {24'h00_0000, req_ff[7:0]} :
                 hit_if1 ? {24'h00_0000, req_ff[15:8]} :
                 hit_if2 ? {24'h00_0000, req_ff[23:16]} :
                 hit_mk0 ? {24'h00_0000, mask_flag_ff[7:0]} :
                 hit_mk1 ? {24'h00_0000, mask_flag_ff[15:8]} :
                 hit_mk2 ? {24'h00_0000, mask_flag_ff[23:16]} :
                 hit_ctrl ? {30'h0000_0000, ctrl_ff} :
                 hit_stat ? status_word : 32'h0000_0000;

  // APB answer, one setup and one access cycle
  assign nxt_pready = apb_setup;
  assign nxt_pslverr = apb_setup & ~mapped;
  assign nxt_prdata = (apb_setup & ~pwrite_in) ? rdata : 32'h0000_0000;
  assign nxt_ctrl = (apb_wr & hit_ctrl) ? pwdata_in[1:0] : ctrl_ff;

  // ----------------------------------------
  // Request and mask flags
  // ----------------------------------------
  // Acknowledge clears the slot or nmi that was offered
  assign ack_take = cpu_ack_in & irq_valid_ff;
  assign ack_nmi = ack_take & irq_nmi_ff;
  assign ack_vec = (ack_take & ~irq_nmi_ff) ? (24'h00_0001 << irq_slot_ff) : 24'h00_0000;

  // Hardware set wins over software write and acknowledge
  assign nxt_req = src_valid & (event_vec | (if_wmask & wdata_rep) |
                   (~if_wmask & req_ff & ~ack_vec));
  assign nxt_nmi = nmi_event | (nmi_ff & ~ack_nmi);

  // Slots that do not exist stay masked
  assign nxt_mask_flag = ~src_valid | (mk_wmask & wdata_rep) | (~mk_wmask & mask_flag_ff);

  // Nmi or any unmasked pending request wakes the core, global enable aside
  assign nxt_standby = nmi_ff | (|(req_ff & ~mask_flag_ff));

  // Offer drops for one cycle after an acknowledge
  assign nxt_irq_valid = arb_bus.win_valid & ~ack_take;

  // Feed the arbiter
  assign arb_bus.req_flags = req_ff[21:0];
  assign arb_bus.masks = mask_flag_ff[21:0];
  assign arb_bus.nmi_pend = nmi_ff;
  assign arb_bus.global_en = global_enable_flag_in;

  vipu_arbiter u_arbiter (
    .core_clk_in (core_clk_in),
    .sys_rst_in (sys_rst_in),
    .bus (arb_bus.arb)
  );

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Flags and control
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      req_ff <= `VIPU_RST_IF;
      mask_flag_ff <= `VIPU_RST_MK;
      ctrl_ff <= `VIPU_RST_CTRL;
      nmi_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      mask_flag_ff <= nxt_mask_flag;
      ctrl_ff <= nxt_ctrl;
      nmi_ff <= nxt_nmi;
    end
  end

  // Bus answer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Processor offer and wake line
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_valid_ff <= 1'b0;
      irq_nmi_ff <= 1'b0;
      irq_vector_ff <= 16'h0000;
      irq_slot_ff <= 5'h00;
      standby_ff <= 1'b0;
    end else begin
      irq_valid_ff <= nxt_irq_valid;
      irq_nmi_ff <= arb_bus.win_nmi & nxt_irq_valid;
      irq_vector_ff <= arb_bus.win_vec;
      irq_slot_ff <= arb_bus.win_idx;
      standby_ff <= nxt_standby;
    end
  end

  // Outputs straight from flops
  assign prdata_out = prdata_ff;
  assign pready_out = pready_ff;
  assign pslverr_out = pslverr_ff;
  assign irq_valid_out = irq_valid_ff;
  assign irq_nmi_out = irq_nmi_ff;
  assign irq_vector_out = irq_vector_ff;
  assign irq_slot_out = irq_slot_ff;
  assign standby_release_out = standby_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  // Non-maskable request reaches the processor two edges after its pulse
  a_nmi_offer_time: assert property (watchdog_irq_in && wdt_nmi_mode && !cpu_ack_in ##1 !cpu_ack_in |=> irq_valid_out && irq_nmi_out && irq_vector_out == 16'h0004)
    else $error("nmi not offered in time");

  a_standby_wake: assert property (nmi_event |-> ##2 standby_release_out)
    else $error("standby release missing after nmi");

  a_wdt_nmi_route: assert property (watchdog_irq_in && wdt_nmi_mode |=> nmi_ff)
    else $error("watchdog mode 1 did not set nmi");

  a_wdt_mask_route: assert property (watchdog_irq_in && !wdt_nmi_mode |=> req_ff[0] && !$rose(nmi_ff))
    else $error("interval mode watchdog misrouted");

  a_wdt_one_path: assert property (watchdog_irq_in && wdt_nmi_mode && !if_wmask[0] |=> !$rose(req_ff[0]))
    else $error("watchdog set both paths");

  a_shared_slot: assert property (serial_rx_done_irq_in || sio_a_done_irq_in |=> req_ff[6])
    else $error("shared serial slot not set");

  // Without cascade a standing flag may still be cleared by its own acknowledge
  a_timer_mode_sel: assert property (
    timer_cascade_match_irq_in && !timer_c_match_irq_in && !if_wmask[12] |=>
    req_ff[12] == ($past(cascade_mode) || ($past(req_ff[12]) && !$past(ack_vec[12]))))
    else $error("timer slot ignores mode");

  a_ack_clears: assert property (ack_take && !irq_nmi_ff && event_vec == 24'h0 && if_wmask == 24'h0 |=> (req_ff & $past(ack_vec)) == 24'h0 && !irq_valid_out)
    else $error("acknowledged flag not cleared");

  a_mask_reset: assert property ($fell(sys_rst_in) |-> mask_flag_ff == 24'hFF_FFFF && req_ff == 24'h0)
    else $error("reset values wrong");

  c_nmi_taken: cover property (irq_nmi_out && cpu_ack_in);
  c_mask_taken: cover property (irq_valid_out && !irq_nmi_out && cpu_ack_in);
  c_two_at_once: cover property (arb_bus.win_valid && $countones(req_ff & ~mask_flag_ff) > 1);
  c_cascade_hit: cover property (cascade_mode && timer_cascade_match_irq_in);
endmodule

// >>> verification/vipu_cpu_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Processor side model
// ----------------------------------------
module vipu_cpu_model (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Offer from the block
  input wire logic valid_in,
  // Bench knobs: allow acks, extra wait cycles
  input wire logic ack_en_in,
  input wire logic [1:0] delay_in,
  // Acknowledge pulse
  output logic ack_out
);
  logic [1:0] wait_ff;

  // Acks a standing offer after a chosen wait, one pulse per offer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_out <= 1'b0;
      wait_ff <= 2'h0;
    end else if (ack_out) begin
      ack_out <= 1'b0; // Pulse lasts one cycle, offer then drops
      wait_ff <= 2'h0;
    end else if (valid_in && ack_en_in) begin
      if (wait_ff >= delay_in) begin
        ack_out <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end else begin
      wait_ff <= 2'h0;
    end
  end
endmodule

// >>> verification/vipu_top_bench.sv
`timescale 1ns/10ps
module vipu_top_bench;
  import vipu_pkg::*;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rnd = 32'd8030;
  logic pready, pslverr, ack, valid, nmi, stby;
  logic [21:0] srcs = 22'h0, ei;
  logic alt = 1'b0, cas = 1'b0, ge = 1'b0, ack_en = 1'b1;
  logic [1:0] dly = 2'h0;
  logic [15:0] vec;
  logic [4:0] slot;
  logic [32:0] exp_rd[$], er;
  logic [21:0] exp_irq[$];
  int miscompares = 0, checked = 0;

  always #5 core_clk_in = ~core_clk_in;

  vipu_top i_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .watchdog_irq_in(srcs[0]), .pin_edge_irq_in(srcs[4:1]), .remote_edge_irq_in(srcs[5]),
    .serial_rx_done_irq_in(srcs[6]), .sio_a_done_irq_in(alt), .sio_b_done_irq_in(srcs[7]),
    .serial_tx_done_irq_in(srcs[8]), .watch_interval_irq_in(srcs[9]),
    .timer_a_match_irq_in(srcs[10]), .timer_b_match_irq_in(srcs[11]),
    .timer_c_match_irq_in(srcs[12]), .timer_cascade_match_irq_in(cas),
    .timer_d_match_irq_in(srcs[13]), .adc_done_irq_in(srcs[14]),
    .watch_overflow_irq_in(srcs[15]), .key_return_a_irq_in(srcs[16]),
    .remote_error_irq_in(srcs[17]), .guide_pulse_irq_in(srcs[18]),
    .remote_rx_done_irq_in(srcs[19]), .shift_data_full_irq_in(srcs[20]),
    .key_return_b_irq_in(srcs[21]), .global_enable_flag_in(ge), .cpu_ack_in(ack),
    .irq_valid_out(valid), .irq_nmi_out(nmi), .irq_vector_out(vec), .irq_slot_out(slot),
    .standby_release_out(stby));

  vipu_cpu_model i_cpu (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .valid_in(valid),
    .ack_en_in(ack_en), .delay_in(dly), .ack_out(ack));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Expected offer of a maskable slot: vector 0004H plus two bytes a slot
  task automatic note(input int s);
    exp_irq.push_back({1'b0, 16'h0004 + 16'(2 * s), 5'(s)});
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic err);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    exp_rd.push_back({err, w ? 32'h0 : d});
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk(32'h0, 32'h1, "no bus answer");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [21:0] m, input logic a, input logic c);
    @(posedge core_clk_in);
    srcs <= m;
    alt <= a;
    cas <= c;
    @(posedge core_clk_in);
    srcs <= 22'h0;
    alt <= 1'b0;
    cas <= 1'b0;
  endtask

  // Waits until only k offers are still expected
  task automatic wait_left(input int k);
    int n;
    n = 0;
    while (exp_irq.size() > k && n < 300) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 300) chk(32'h0, 32'h1, "offer missing");
    repeat (3) @(posedge core_clk_in);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Monitor: compares each result with the oldest note
  // ----------------------------------------
  always @(posedge core_clk_in) begin
    if (pready === 1'b1 && exp_rd.size() != 0) begin
      er = exp_rd.pop_front();
      chk({31'h0, pslverr}, {31'h0, er[32]}, "slverr");
      chk(prdata, er[31:0], "rdata");
    end
    if (valid === 1'b1 && ack === 1'b1) begin
      if (exp_irq.size() != 0) begin
        ei = exp_irq.pop_front();
        chk({nmi, vec, nmi ? 5'h00 : slot}, {10'h0, ei}, "offer");
      end else chk(32'h0, 32'h1, "unexpected offer");
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    for (int a = 12; a <= 20; a += 4) apb(1'b0, 32'(a), 32'hFF, 1'b0);
    apb(1'b0, 32'h00, 32'h0, 1'b0);
    apb(1'b0, 32'h20, 32'h0, 1'b1);
    for (int a = 12; a <= 20; a += 4) apb(1'b1, 32'(a), 32'h0, 1'b0);
    apb(1'b0, 32'h14, 32'hC0, 1'b0);
    ge <= 1'b1;
    // Each source alone lands on its own slot and vector
    for (int s = 0; s < 22; s++) begin
      note(s);
      pulse(22'h1 << s, 1'b0, 1'b0);
      @(posedge core_clk_in);
      #1 chk({31'h0, stby}, 32'h1, "standby");
      wait_left(0);
    end
    note(6);
    pulse(22'h0, 1'b1, 1'b0);
    wait_left(0);
    apb(1'b1, 32'h18, 32'h2, 1'b0);
    note(12);
    pulse(22'h0, 1'b0, 1'b1);
    wait_left(0);
    apb(1'b1, 32'h18, 32'h0, 1'b0);
    // Random groups arriving together, lowest slot first
    repeat (5) begin
      repeat (24) rnd = lfsr(rnd);
      dly <= rnd[31:30];
      for (int s = 0; s < 22; s++) if (rnd[s]) note(s);
      pulse(rnd[21:0], 1'b0, 1'b0);
      wait_left(0);
    end
    // Masked slot is flagged but not offered
    apb(1'b1, 32'h0C, 32'h02, 1'b0);
    pulse(22'h2, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk_in);
    #1 chk({30'h0, valid, stby}, 32'h0, "masked offer");
    apb(1'b0, 32'h00, 32'h02, 1'b0);
    note(1);
    apb(1'b1, 32'h0C, 32'h0, 1'b0);
    wait_left(0);
    // Watchdog as non-maskable source, global enable off
    apb(1'b1, 32'h18, 32'h1, 1'b0);
    apb(1'b0, 32'h18, 32'h1, 1'b0);
    ge <= 1'b0;
    exp_irq.push_back({1'b1, 16'h0004, 5'h00});
    note(3);
    pulse(22'h8, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk_in);
    #1 chk({30'h0, valid, stby}, 32'h1, "enable off");
    pulse(22'h1, 1'b0, 1'b0);
    wait_left(1);
    ge <= 1'b1;
    wait_left(0);
    apb(1'b0, 32'h00, 32'h0, 1'b0);
    // Non-maskable overtakes a standing maskable offer
    ack_en <= 1'b0;
    exp_irq.push_back({1'b1, 16'h0004, 5'h00});
    note(3);
    pulse(22'h8, 1'b0, 1'b0);
    // Status shows the standing offer: vector 000AH, slot 3, valid
    apb(1'b0, 32'h1C, 32'h000A_0302, 1'b0);
    pulse(22'h1, 1'b0, 1'b0);
    @(posedge core_clk_in);
    ack_en <= 1'b1;
    wait_left(0);
    // Reset in mid-run drops a pending flag and masks every slot again
    ack_en <= 1'b0;
    pulse(22'h8, 1'b0, 1'b0);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    ack_en <= 1'b1;
    apb(1'b0, 32'h00, 32'h0, 1'b0);
    apb(1'b0, 32'h0C, 32'hFF, 1'b0);
    #1 chk({30'h0, valid, stby}, 32'h0, "offer after reset");
    report_and_stop();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge core_clk_in);
    miscompares++;
    $display("ERROR %0t run did not finish", $time);
    report_and_stop();
  end
endmodule
